//--- rtl/bcc_exec.sv
// Executor for banked call/return, accumulator compare and clear operations
//
// Contract
// - Call lowers stack by two, stores return
// - Return address is the following instruction
// - Then lowers stack once, pushes page
// - Then loads new page and subroutine address
// - Indirect call reads high, low, page
// - Banked return restores address and page
// - Call works without expanded memory too
// - Compare subtracts B from A, keeps both
// - N copies MSB, Z on zero result
// - Overflow from signed compare equation
// - Carry is borrow out of MSB
// - Carry clear is flag AND FE
// - Mask clear is flag AND EF
// - Clear mask lets interrupts through
// - Mask clear acts one cycle late
// - Memory zero writes 0, flags 0100
// - A zero clears A, sets Z
// - B zero clears B, sets Z
// - Overflow clear is flag AND FD
`timescale 1ns/1ns
module bcc_exec
  import bcc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Instruction in
  input  wire bcc_instr_t   instr,
  output logic              instrReady,
  // Memory
  output bcc_mem_req_t      memReq,
  input  wire logic         memAck,
  input  wire logic [7:0]   memRdata,
  // Interrupt
  input  wire logic         irqReq,
  output logic              irqTake,
  // Architectural state
  output logic [7:0]        accA,
  output logic [7:0]        accB,
  output logic [7:0]        conditionFlags,
  output logic [15:0]       stackPointer,
  output logic [15:0]       programCounter,
  output logic [7:0]        programPage
);

  typedef enum logic [3:0] {
    S_IDLE, S_IND_HI, S_IND_LO, S_IND_PG, S_PUSH_HI, S_PUSH_LO, S_PUSH_PG,
    S_RET_PG, S_RET_HI, S_RET_LO, S_ZERO_WR
  } bcc_state_t;

  // ==========================================================================
  // Registers
  bcc_state_t   state_reg, state_next;
  logic [7:0]   accA_reg, accA_next;
  logic [7:0]   accB_reg, accB_next;
  logic [7:0]   ccr_reg, ccr_next;
  logic [15:0]  sp_reg, sp_next;
  logic [15:0]  pc_reg, pc_next;
  logic [7:0]   page_reg, page_next;
  logic [15:0]  rtn_reg, rtn_next;
  logic [15:0]  tgt_reg, tgt_next;
  logic [7:0]   newPg_reg, newPg_next;
  logic [15:0]  ptr_reg, ptr_next;
  logic         maskLate_reg;
  bcc_mem_req_t req_reg, req_next;

  // ==========================================================================
  // Decode
  wire logic isIdle     = (state_reg == S_IDLE);
  wire logic go         = isIdle & instr.valid;
  wire logic isCall     = (instr.op0 == OP_CALL_EXT) | (instr.op0 == OP_CALL_IDX);
  wire logic isRet      = (instr.op0 == OP_BANK_RET);
  wire logic isCmp      = (instr.op0 == OP_PREFIX2) & (instr.op1 == OP_ACC_CMP2);
  wire logic isAndCc    = (instr.op0 == OP_FLAG_AND);
  wire logic isMemZero  = (instr.op0 == OP_MEM_ZERO_E) | (instr.op0 == OP_MEM_ZERO_X);
  wire logic isAZero    = (instr.op0 == OP_ACC_A_ZERO);
  wire logic isBZero    = (instr.op0 == OP_ACC_B_ZERO);
  wire logic clearsMask = isAndCc & ~instr.op1[FLAG_I] & ccr_reg[FLAG_I];

  logic cmpN, cmpZ, cmpV, cmpC;

  bcc_compare_alu u_alu (
    .opA       (accA_reg),
    .opB       (accB_reg),
    .negFlag   (cmpN),
    .zeroFlag  (cmpZ),
    .ovfFlag   (cmpV),
    .carryFlag (cmpC)
  );

  // Zero-result flags: N, V, C cleared and Z set; others untouched
  function automatic logic [7:0] zeroFlags(input logic [7:0] f);
    logic [7:0] r;
    r         = f;
    r[FLAG_N] = 1'b0;
    r[FLAG_Z] = 1'b1;
    r[FLAG_V] = 1'b0;
    r[FLAG_C] = 1'b0;
    return r;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    accA_next  = accA_reg;
    accB_next  = accB_reg;
    ccr_next   = ccr_reg;
    sp_next    = sp_reg;
    pc_next    = pc_reg;
    page_next  = page_reg;
    rtn_next   = rtn_reg;
    tgt_next   = tgt_reg;
    newPg_next = newPg_reg;
    ptr_next   = ptr_reg;
    req_next   = '0;
    case (state_reg)
      S_IDLE: begin
        if (go) begin
          pc_next = instr.nextPc;
          if (isCall) begin
            rtn_next   = instr.nextPc;
            tgt_next   = instr.ea;
            newPg_next = instr.page;
            if (instr.indirect) begin
              ptr_next   = instr.ea;
              req_next   = '{1'b1, 1'b0, instr.ea, 8'h00};
              state_next = S_IND_HI;
            end else begin
              sp_next    = sp_reg - 16'h0002;
              req_next   = '{1'b1, 1'b1, sp_reg - 16'h0002, instr.nextPc[15:8]};
              state_next = S_PUSH_HI;
            end
          end else if (isRet) begin
            req_next   = '{1'b1, 1'b0, sp_reg, 8'h00};
            state_next = S_RET_PG;
          end else if (isCmp) begin
            ccr_next[FLAG_N] = cmpN;
            ccr_next[FLAG_Z] = cmpZ;
            ccr_next[FLAG_V] = cmpV;
            ccr_next[FLAG_C] = cmpC;
          end else if (isAndCc) begin
            // Mask bit falls one cycle later through maskLate_reg
            ccr_next         = ccr_reg & instr.op1;
            ccr_next[FLAG_I] = ccr_reg[FLAG_I] & (instr.op1[FLAG_I] | clearsMask);
          end else if (isMemZero) begin
            req_next   = '{1'b1, 1'b1, instr.ea, 8'h00};
            state_next = S_ZERO_WR;
          end else if (isAZero) begin
            accA_next = 8'h00;
            ccr_next  = zeroFlags(ccr_reg);
          end else if (isBZero) begin
            accB_next = 8'h00;
            ccr_next  = zeroFlags(ccr_reg);
          end
        end
      end
      S_IND_HI: begin
        req_next = req_reg;
        if (memAck) begin
          tgt_next[15:8] = memRdata;
          req_next       = '{1'b1, 1'b0, ptr_reg + 16'h0001, 8'h00};
          state_next     = S_IND_LO;
        end
      end
      S_IND_LO: begin
        req_next = req_reg;
        if (memAck) begin
          tgt_next[7:0] = memRdata;
          req_next      = '{1'b1, 1'b0, ptr_reg + 16'h0002, 8'h00};
          state_next    = S_IND_PG;
        end
      end
      S_IND_PG: begin
        req_next = req_reg;
        if (memAck) begin
          newPg_next = memRdata;
          sp_next    = sp_reg - 16'h0002;
          req_next   = '{1'b1, 1'b1, sp_reg - 16'h0002, rtn_reg[15:8]};
          state_next = S_PUSH_HI;
        end
      end
      S_PUSH_HI: begin
        req_next = req_reg;
        if (memAck) begin
          req_next   = '{1'b1, 1'b1, sp_reg + 16'h0001, rtn_reg[7:0]};
          state_next = S_PUSH_LO;
        end
      end
      S_PUSH_LO: begin
        req_next = req_reg;
        if (memAck) begin
          sp_next    = sp_reg - 16'h0001;
          req_next   = '{1'b1, 1'b1, sp_reg - 16'h0001, page_reg};
          state_next = S_PUSH_PG;
        end
      end
      S_PUSH_PG: begin
        req_next = req_reg;
        if (memAck) begin
          // Page register exists even without expanded memory
          page_next  = newPg_reg;
          pc_next    = tgt_reg;
          req_next   = '0;
          state_next = S_IDLE;
        end
      end
      S_RET_PG: begin
        req_next = req_reg;
        if (memAck) begin
          page_next  = memRdata;
          req_next   = '{1'b1, 1'b0, sp_reg + 16'h0001, 8'h00};
          state_next = S_RET_HI;
        end
      end
      S_RET_HI: begin
        req_next = req_reg;
        if (memAck) begin
          pc_next[15:8] = memRdata;
          req_next      = '{1'b1, 1'b0, sp_reg + 16'h0002, 8'h00};
          state_next    = S_RET_LO;
        end
      end
      S_RET_LO: begin
        req_next = req_reg;
        if (memAck) begin
          pc_next[7:0] = memRdata;
          sp_next      = sp_reg + 16'h0003;
          req_next     = '0;
          state_next   = S_IDLE;
        end
      end
      S_ZERO_WR: begin
        req_next = req_reg;
        if (memAck) begin
          ccr_next   = zeroFlags(ccr_reg);
          req_next   = '0;
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
    if (maskLate_reg) begin
      ccr_next[FLAG_I] = 1'b0;
    end
  end

  // ==========================================================================
  // State
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      accA_reg     <= 8'h00;
      accB_reg     <= 8'h00;
      ccr_reg      <= CCR_RESET;
      sp_reg       <= SP_RESET;
      pc_reg       <= PC_RESET;
      page_reg     <= PAGE_RESET;
      rtn_reg      <= 16'h0000;
      tgt_reg      <= 16'h0000;
      newPg_reg    <= 8'h00;
      ptr_reg      <= 16'h0000;
      maskLate_reg <= 1'b0;
      req_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      accA_reg     <= accA_next;
      accB_reg     <= accB_next;
      ccr_reg      <= ccr_next;
      sp_reg       <= sp_next;
      pc_reg       <= pc_next;
      page_reg     <= page_next;
      rtn_reg      <= rtn_next;
      tgt_reg      <= tgt_next;
      newPg_reg    <= newPg_next;
      ptr_reg      <= ptr_next;
      maskLate_reg <= go & clearsMask;
      req_reg      <= req_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Interrupts only taken between instructions, once the mask is low
  assign irqTake        = isIdle & ~instr.valid & irqReq & ~ccr_reg[FLAG_I];
  assign instrReady     = isIdle;
  assign memReq         = req_reg;
  assign accA           = accA_reg;
  assign accB           = accB_reg;
  assign conditionFlags = ccr_reg;
  assign stackPointer   = sp_reg;
  assign programCounter = pc_reg;
  assign programPage    = page_reg;

  // ==========================================================================
  // Checks
  AST_CALL_SP: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_PUSH_LO && memAck) |=> (sp_reg == $past(sp_reg) - 16'h0001))
    else $error("call page push did not lower stack by one");
  AST_CALL_RTN: assert property (@(posedge clk) disable iff (rst)
    (go && isCall) |=> (rtn_reg == $past(instr.nextPc)))
    else $error("return address not the following instruction");
  AST_PUSH_PG: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_PUSH_PG) |-> (memReq.write && memReq.wdata == page_reg))
    else $error("page push carries wrong value");
  AST_CALL_PC: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_PUSH_PG && memAck) |=>
      (pc_reg == $past(tgt_reg) && page_reg == $past(newPg_reg)))
    else $error("call did not load page and target");
  AST_CMP_KEEP: assert property (@(posedge clk) disable iff (rst)
    (go && isCmp) |=> ($stable(accA_reg) && $stable(accB_reg)))
    else $error("compare altered an accumulator");
  AST_CMP_Z: assert property (@(posedge clk) disable iff (rst)
    (go && isCmp) |=> (ccr_reg[FLAG_Z] == ($past(accA_reg) == $past(accB_reg))))
    else $error("compare zero flag wrong");
  AST_CMP_C: assert property (@(posedge clk) disable iff (rst)
    (go && isCmp) |=> (ccr_reg[FLAG_C] == ($past(accA_reg) < $past(accB_reg))))
    else $error("compare carry flag wrong");
  AST_MASK_LATE: assert property (@(posedge clk) disable iff (rst)
    (go && clearsMask) |=> ccr_reg[FLAG_I] ##1 !ccr_reg[FLAG_I])
    else $error("mask clear not one cycle late");
  AST_A_ZERO: assert property (@(posedge clk) disable iff (rst)
    (go && isAZero) |=> (accA_reg == 8'h00 && ccr_reg[3:0] == 4'h4))
    else $error("A zero wrong");
  AST_ZERO_WR: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_ZERO_WR) |-> (memReq.valid && memReq.write && memReq.wdata == 8'h00))
    else $error("memory zero writes a nonzero byte");
  AST_RET_SP: assert property (@(posedge clk) disable iff (rst)
    (state_reg == S_RET_LO && memAck) |=> (sp_reg == $past(sp_reg) + 16'h0003))
    else $error("return did not release three stack bytes");
  // A mask clear still in flight may drop I under these ops; that is not their doing
  AST_KEEP_HI: assert property (@(posedge clk) disable iff (rst)
    (go && (isCmp || isAZero || isBZero)) |=> (ccr_reg[7:5] == $past(ccr_reg[7:5]) &&
      ccr_reg[FLAG_I] == ($past(ccr_reg[FLAG_I]) && !$past(maskLate_reg))))
    else $error("untouched flags changed");

  COV_CALL:  cover property (@(posedge clk) disable iff (rst) go && isCall && instr.indirect);
  COV_RET:   cover property (@(posedge clk) disable iff (rst) go && isRet);
  COV_CMP:   cover property (@(posedge clk) disable iff (rst) go && isCmp);
  COV_IRQ:   cover property (@(posedge clk) disable iff (rst) irqTake);
  COV_MASK:  cover property (@(posedge clk) disable iff (rst) go && clearsMask);

endmodule

//--- rtl/bcc_pkg.sv
// Package: constants and types for the banked call / clear / compare executor
package bcc_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_CALL_EXT   = 8'h4a;
  localparam logic [7:0] OP_CALL_IDX   = 8'h4b;
  localparam logic [7:0] OP_PREFIX2    = 8'h18;
  localparam logic [7:0] OP_ACC_CMP2   = 8'h17;
  localparam logic [7:0] OP_FLAG_AND   = 8'h10;
  localparam logic [7:0] MASK_CARRY    = 8'hfe;
  localparam logic [7:0] MASK_IMASK    = 8'hef;
  localparam logic [7:0] MASK_OVF      = 8'hfd;
  localparam logic [7:0] OP_MEM_ZERO_E = 8'h79;
  localparam logic [7:0] OP_MEM_ZERO_X = 8'h69;
  localparam logic [7:0] OP_ACC_A_ZERO = 8'h87;
  localparam logic [7:0] OP_ACC_B_ZERO = 8'hc7;
  localparam logic [7:0] OP_BANK_RET   = 8'h0a;

  // ==========================================================================
  // Flag bit positions in condition_flags
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  CCR_RESET   = 8'hd0;
  localparam logic [15:0] SP_RESET    = 16'h0000;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  PAGE_RESET  = 8'h00;
  localparam int          IMASK_DELAY = 1;

  // ==========================================================================
  // Memory request carrier
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bcc_mem_req_t;

  // Instruction as presented by the fetch unit
  typedef struct packed {
    logic       valid;
    logic [7:0] op0;
    logic [7:0] op1;
    logic [15:0] ea;
    logic [7:0] page;
    logic       indirect;
    logic [15:0] nextPc;
  } bcc_instr_t;

endpackage

//--- rtl/bcc_compare_alu.sv
// Subtract-and-flag unit for the accumulator compare
`timescale 1ns/1ns
module bcc_compare_alu
  import bcc_pkg::*;
(
  // Operands
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  // Flags
  output logic            negFlag,
  output logic            zeroFlag,
  output logic            ovfFlag,
  output logic            carryFlag
);

  logic [7:0] result;
  logic       a7;
  logic       b7;
  logic       r7;

  assign result    = opA - opB;
  assign a7        = opA[7];
  assign b7        = opB[7];
  assign r7        = result[7];
  assign negFlag   = r7;
  assign zeroFlag  = (result == 8'h00);
  assign ovfFlag   = (a7 & ~b7 & ~r7) | (~a7 & b7 & r7);
  assign carryFlag = (~a7 & b7) | (b7 & r7) | (r7 & ~a7);

endmodule

//--- bench/bcc_mem_model.sv
// Behavioural memory that answers the executor's byte requests after a set wait
`timescale 1ns/1ns
module bcc_mem_model
  import bcc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Request side
  input  wire bcc_mem_req_t memReq,
  input  wire logic [3:0]   waitCycles,
  // Answer side
  output logic              memAck,
  output logic [7:0]        memRdata
);
  // ==========================================================================
  // Storage and wait counter
  logic [7:0] mem [0:65535];
  logic [3:0] waitReg;

  // Plain always: the bench preloads mem by hierarchy, so this is not always_ff
  always @(posedge clk) begin
    if (rst) begin
      memAck   <= 1'h0;
      memRdata <= 8'h00;
      waitReg  <= 4'h0;
    end else if (memAck) begin
      memAck   <= 1'h0;
      memRdata <= ~memRdata;
    end else if (memReq.valid && waitReg >= waitCycles) begin
      memAck  <= 1'h1;
      waitReg <= 4'h0;
      if (memReq.write) begin
        mem[memReq.addr] <= memReq.wdata;
        memRdata         <= ~memRdata;
      end else begin
        memRdata <= mem[memReq.addr];
      end
    end else begin
      // Stale data toggles so a late sample never looks like a real answer
      memRdata <= ~memRdata;
      if (memReq.valid) begin
        waitReg <= waitReg + 4'h1;
      end
    end
  end
endmodule

//--- bench/tb.sv
// Testbench: single-cycle op table, calls, returns, memory clear and mask timing
`timescale 1ns/1ns
module tb;
  import bcc_pkg::*;
  // ==========================================================================
  // Signals
  typedef struct {logic [7:0] op0; logic [7:0] op1; logic [7:0] fl;} bcc_row_t;
  localparam int NROWS = 9;
  logic         clk, rst, instrReady, memAck, irqReq, irqTake;
  bcc_instr_t   instr;
  bcc_mem_req_t memReq;
  logic [7:0]   memRdata, accA, accB, conditionFlags, programPage;
  logic [15:0]  stackPointer, programCounter;
  logic [3:0]   memLat;
  logic [31:0]  seenQ[$];
  logic [31:0]  expLog[$];
  bcc_row_t     rows [NROWS];
  int           nFail, totalChecks, cycles;

  bcc_exec i_dut (.clk(clk), .rst(rst), .instr(instr), .instrReady(instrReady),
    .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .irqReq(irqReq),
    .irqTake(irqTake), .accA(accA), .accB(accB), .conditionFlags(conditionFlags),
    .stackPointer(stackPointer), .programCounter(programCounter), .programPage(programPage));
  bcc_mem_model i_mem (.clk(clk), .rst(rst), .memReq(memReq), .waitCycles(memLat),
    .memAck(memAck), .memRdata(memRdata));

  // ==========================================================================
  // Clock, timeout and memory traffic log
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      wrap_up();
    end
    if (memReq.valid && memAck) begin
      seenQ.push_back({7'h00, memReq.write, memReq.addr, memReq.write ? memReq.wdata : memRdata});
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic bcc_instr_t mk(logic [7:0] o0, logic [7:0] o1, logic [15:0] ea,
                                    logic [7:0] pg, logic ind, logic [15:0] npc);
    return {1'h1, o0, o1, ea, pg, ind, npc};
  endfunction

  // Present one instruction, drop valid at the taking edge, wait for idle
  task automatic issue(bcc_instr_t ins);
    int n;
    n = 0;
    seenQ.delete();
    @(posedge clk) instr <= ins;
    @(posedge clk) instr.valid <= 1'h0;
    #1;
    while (!instrReady && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("idleAfterOp", 32'(instrReady), 32'h1);
  endtask

  task automatic chk_log(logic [31:0] e[$]);
    check("memCount", 32'(seenQ.size()), 32'(e.size()));
    foreach (e[k]) check("memAccess", (k < seenQ.size()) ? seenQ[k] : 32'hffffffff, e[k]);
  endtask

  task automatic chk_state(logic [15:0] sp, logic [15:0] pc, logic [7:0] pg, logic [7:0] fl);
    check("stackPointer", 32'(stackPointer), 32'(sp));
    check("programCounter", 32'(programCounter), 32'(pc));
    check("programPage", 32'(programPage), 32'(pg));
    check("flags", 32'(conditionFlags), 32'(fl));
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    instr = '0;
    irqReq = 1'h0;
    memLat = 4'h0;
    nFail = 0;
    totalChecks = 0;
    cycles = 0;
    // Z is knocked down by AND FB first, so each clear must raise it again
    rows = '{'{8'h10, 8'hfb, 8'hd0}, '{8'h87, 8'h00, 8'hd4}, '{8'h10, 8'hfb, 8'hd0},
             '{8'hc7, 8'h00, 8'hd4}, '{8'h10, 8'hfb, 8'hd0}, '{8'h18, 8'h17, 8'hd4},
             '{8'h10, 8'hfe, 8'hd4}, '{8'h10, 8'hfd, 8'hd4}, '{8'h5a, 8'h00, 8'hd4}};
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk_state(16'h0000, 16'h0000, 8'h00, 8'hd0);
    check("accAReset", 32'(accA), 32'h0);
    check("readyReset", 32'(instrReady), 32'h1);
    // Back-to-back single-cycle ops
    for (int i = 0; i <= NROWS; i++) begin
      @(posedge clk);
      if (i < NROWS) instr <= mk(rows[i].op0, rows[i].op1, 16'h0, 8'h0, 1'h0, 16'h0100 + 16'(i));
      else instr.valid <= 1'h0;
      #1;
      if (i > 0) begin
        check("rowFlags", 32'(conditionFlags), 32'(rows[i-1].fl));
        check("rowPc", 32'(programCounter), 32'h0100 + 32'(i - 1));
        check("rowAccA", 32'(accA), 32'h0);
        check("rowAccB", 32'(accB), 32'h0);
      end
    end
    // Memory zero, extended then indexed
    memLat <= 4'h1;
    i_mem.mem[16'h0010] = 8'hff;
    i_mem.mem[16'h0011] = 8'h5a;
    issue(mk(8'h10, 8'hfb, 16'h0, 8'h0, 1'h0, 16'h0200));
    issue(mk(8'h79, 8'h00, 16'h0010, 8'h0, 1'h0, 16'h0203));
    expLog = '{32'h01001000};
    chk_log(expLog);
    issue(mk(8'h10, 8'hfb, 16'h0, 8'h0, 1'h0, 16'h0204));
    issue(mk(8'h69, 8'h00, 16'h0011, 8'h0, 1'h0, 16'h0206));
    expLog = '{32'h01001100};
    chk_log(expLog);
    check("zeroFlags", 32'(conditionFlags), 32'hd4);
    // Direct call with a prompt memory
    memLat <= 4'h0;
    issue(mk(8'h4a, 8'h00, 16'h1234, 8'h05, 1'h0, 16'h0104));
    expLog = '{32'h01fffe01, 32'h01ffff04, 32'h01fffd00};
    chk_log(expLog);
    chk_state(16'hfffd, 16'h1234, 8'h05, 8'hd4);
    // Indirect call with a slow memory
    memLat <= 4'h3;
    i_mem.mem[16'h0200] = 8'h45;
    i_mem.mem[16'h0201] = 8'h67;
    i_mem.mem[16'h0202] = 8'h09;
    issue(mk(8'h4b, 8'h00, 16'h0200, 8'h00, 1'h1, 16'h0300));
    expLog = '{32'h00020045, 32'h00020167, 32'h00020209,
               32'h01fffb03, 32'h01fffc00, 32'h01fffa05};
    chk_log(expLog);
    chk_state(16'hfffa, 16'h4567, 8'h09, 8'hd4);
    // Two returns unwind both calls
    issue(mk(8'h0a, 8'h00, 16'h0, 8'h0, 1'h0, 16'h4568));
    expLog = '{32'h00fffa05, 32'h00fffb03, 32'h00fffc00};
    chk_log(expLog);
    chk_state(16'hfffd, 16'h0300, 8'h05, 8'hd4);
    issue(mk(8'h0a, 8'h00, 16'h0, 8'h0, 1'h0, 16'h0301));
    chk_state(16'h0000, 16'h0104, 8'h00, 8'hd4);
    // Mask clear with an interrupt already pending
    @(posedge clk) irqReq <= 1'h1;
    @(posedge clk);
    #1;
    check("irqMasked", 32'(irqTake), 32'h0);
    @(posedge clk) instr <= mk(8'h10, 8'hef, 16'h0, 8'h0, 1'h0, 16'h0500);
    @(posedge clk) instr <= mk(8'hc7, 8'h00, 16'h0, 8'h0, 1'h0, 16'h0501);
    #1;
    check("irqHeldBack", 32'(irqTake), 32'h0);
    // The mask must still read set in the cycle after the flag AND is taken
    check("maskHeld", 32'(conditionFlags[FLAG_I]), 32'h1);
    @(posedge clk) instr.valid <= 1'h0;
    #1;
    check("irqAccepted", 32'(irqTake), 32'h1);
    check("maskFlags", 32'(conditionFlags), 32'hc4);
    check("nextOpPc", 32'(programCounter), 32'h0501);
    // Mid-run reset puts the state back and masks the still-pending request
    @(posedge clk) rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk_state(16'h0000, 16'h0000, 8'h00, 8'hd0);
    check("irqAfterReset", 32'(irqTake), 32'h0);
    wrap_up();
  end
endmodule
